// ===== arith_params.svh
`ifndef ARITH_PARAMS_SVH
`define ARITH_PARAMS_SVH

// register byte offsets
`define OFS_CMD      8'h00
`define OFS_LOAD     8'h04
`define OFS_ACC      8'h08
`define OFS_TOP      8'h0c
`define OFS_FLAGS    8'h10

// field positions in the status and command words
`define FLAGS_MSB    8
`define BUSY_BIT     16
`define OP_MSB       2

// reset values
`define ACC_RST      32'h0000_0000
`define STK_RST      32'h0000_0000
`define FLAGS_RST    9'h000

// divide step count and stack depth
`define DIV_STEPS    6'h20
`define STK_DEPTH    8

`endif

// ===== arith_pkg.sv
package arith_pkg;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_ADD = 3'h1,
        OP_SUB = 3'h2,
        OP_MUL = 3'h3,
        OP_DIV = 3'h4
    } op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_DIV  = 1'b1
    } state_t;

    typedef struct packed {
        logic range_err_flag;
        logic invalid_digit_flag;
        logic signed_overflow_flag;
        logic negative_result_flag;
        logic full_width_carry_flag;
        logic low_half_carry_flag;
        logic full_width_borrow_flag;
        logic low_half_borrow_flag;
        logic zero_result_flag;
    } flags_t;

endpackage

// ===== restoring_divider.sv
`timescale 1ns/1ps
`include "arith_params.svh"

module restoring_divider (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [31:0] dividend_i,
    input  wire logic [15:0] divisor_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [31:0]      quot_o,
    output logic [15:0]      rem_o
);
    logic [5:0]  cnt_r;
    logic [15:0] dsr_r;
    logic [16:0] rem_sh;
    logic [16:0] trial;

    // one quotient bit per clock keeps the adder 17 bits wide
    assign rem_sh = {rem_o, quot_o[31]};
    assign trial  = rem_sh - {1'b0, dsr_r};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            cnt_r  <= 6'h00;
            dsr_r  <= 16'h0000;
            quot_o <= 32'h0000_0000;
            rem_o  <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            if (!busy_o && start_i) begin
                busy_o <= 1'b1;
                cnt_r  <= 6'h00;
                dsr_r  <= divisor_i;
                quot_o <= dividend_i;
                rem_o  <= 16'h0000;
            end else if (busy_o) begin
                if (!trial[16]) begin
                    rem_o  <= trial[15:0];
                    quot_o <= {quot_o[30:0], 1'b1};
                end else begin
                    rem_o  <= rem_sh[15:0];
                    quot_o <= {quot_o[30:0], 1'b0};
                end
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r == `DIV_STEPS - 6'h01) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    div_latency_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
        (start_i && !busy_o) |-> ##33 done_o)
        else $error("divider did not finish in 32 steps");
endmodule

// ===== stack_arith_unit.sv
`timescale 1ns/1ps
`include "arith_params.svh"

// Summary of operation
// RQ1 - decimal divide: 8-digit accumulator by 4-digit top
// RQ2 - divide remainder replaces top level, no pop
// RQ3 - divide sets range flag on unusable divisor
// RQ4 - non-BCD operand in decimal op sets invalid flag
// RQ5 - zero flag set when accumulator result is zero
// RQ6 - sign flag set when accumulator result negative
// RQ7 - binary add: accumulator plus top into accumulator
// RQ8 - binary ops pop top, stack moves up
// RQ9 - add sets low-half carry out of bit 15
// RQ10 - add sets full carry out of bit 31
// RQ11 - signed overflow flag on wrong sign bit
// RQ12 - binary subtract: accumulator minus top into accumulator
// RQ13 - subtract sets low-half borrow flag
// RQ14 - subtract sets full-width borrow flag
// RQ15 - multiply low 16 bits of top and accumulator
// RQ16 - multiply keeps full 32-bit product
// RQ17 - flags hold until an op affecting them
// RQ18 - load pushes old accumulator onto stack
// RQ19 - eight levels, push drops deepest, pop leaves it
// RQ20 - any digit above nine is invalid

module stack_arith_unit (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic             ack_o,
    output logic [31:0]      dat_o
);
    typedef enum logic [1:0] {STK_HOLD, STK_PUSH, STK_POP, STK_TOP} stk_act_t;

    logic [31:0]          acc_r;
    logic [31:0]          acc_nxt;
    logic [31:0]          stk_r [0:`STK_DEPTH-1];
    logic [31:0]          top_nxt;
    stk_act_t             stk_act;
    arith_pkg::flags_t    flags_r;
    arith_pkg::flags_t    flags_nxt;
    arith_pkg::state_t    state_r;
    arith_pkg::op_t       op;
    logic                 ack_r;
    logic [31:0]          rd_r;
    logic [31:0]          rd_mux;
    logic                 req;
    logic                 wr_ev;
    logic                 idle;
    logic                 ld_go;
    logic                 op_go;
    logic [31:0]          ld_val;
    logic [32:0]          sum33;
    logic [16:0]          sum17;
    logic [32:0]          dif33;
    logic [31:0]          prod;
    logic                 div_ok;
    logic                 div_start;
    logic                 dv_busy;
    logic                 dv_done;
    logic [31:0]          dv_quot;
    logic [15:0]          dv_rem;
    logic [15:0]          dv_dsr;

    function automatic logic bcd_ok(input logic [31:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (v[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [31:0] bcd_to_bin(input logic [31:0] v);
        logic [31:0] acc;
        acc = 32'h0000_0000;
        for (int i = 7; i >= 0; i--) begin
            acc = 32'((acc << 3) + (acc << 1) + {28'h0000000, v[4*i +: 4]});
        end
        return acc;
    endfunction

    // quotient never exceeds eight digits, so dropped top carries are zero
    function automatic logic [31:0] bin_to_bcd(input logic [31:0] v);
        logic [31:0] bcd;
        bcd = 32'h0000_0000;
        for (int i = 31; i >= 0; i--) begin
            for (int d = 0; d < 8; d++) begin
                if (bcd[4*d +: 4] > 4'h4) begin
                    bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
                end
            end
            bcd = {bcd[30:0], v[i]};
        end
        return bcd;
    endfunction

    // bus: ack one cycle after the request, write acts on the ack edge
    assign req   = cyc_i && stb_i;
    assign wr_ev = req && we_i && ack_r;
    assign idle  = (state_r == arith_pkg::ST_IDLE);
    assign op    = arith_pkg::op_t'(dat_i[`OP_MSB:0]);
    // writes while a divide runs are acked but ignored; reads are served
    assign ld_go = wr_ev && idle && (adr_i[7:0] == `OFS_LOAD);
    assign op_go = wr_ev && idle && sel_i[0] && (adr_i[7:0] == `OFS_CMD);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ld_val[8*i +: 8] = sel_i[i] ? dat_i[8*i +: 8] : 8'h00;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (adr_i[7:0])
            `OFS_ACC:   rd_mux = acc_r;
            `OFS_TOP:   rd_mux = stk_r[0];
            `OFS_FLAGS: begin
                rd_mux[`FLAGS_MSB:0] = flags_r;
                rd_mux[`BUSY_BIT]    = !idle;
            end
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rd_r  <= 32'h0000_0000;
        end else begin
            ack_r <= req && !ack_r;
            if (req && !ack_r) begin
                rd_r <= rd_mux;
            end
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rd_r;

    // datapath
    assign sum33 = {1'b0, acc_r} + {1'b0, stk_r[0]};                  // RQ7
    assign sum17 = {1'b0, acc_r[15:0]} + {1'b0, stk_r[0][15:0]};
    assign dif33 = {1'b0, acc_r} - {1'b0, stk_r[0]};                  // RQ12
    assign prod  = {16'h0000, acc_r[15:0]} * {16'h0000, stk_r[0][15:0]}; // RQ15
    // divisor must be 1..9999, i.e. upper four digits clear
    assign div_ok    = bcd_ok(acc_r) && bcd_ok(stk_r[0]) && (stk_r[0][31:16] == 16'h0000)
                       && (stk_r[0][15:0] != 16'h0000);
    assign div_start = op_go && (op == arith_pkg::OP_DIV) && div_ok;
    // a legal divisor is at most 9999, so the cut drops only zeros
    assign dv_dsr    = 16'(bcd_to_bin(stk_r[0]));

    restoring_divider u_div (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .start_i    (div_start),
        .dividend_i (bcd_to_bin(acc_r)),                             // RQ1
        .divisor_i  (dv_dsr),
        .busy_o     (dv_busy),
        .done_o     (dv_done),
        .quot_o     (dv_quot),
        .rem_o      (dv_rem)
    );

    always_comb begin
        acc_nxt   = acc_r;
        top_nxt   = stk_r[0];
        stk_act   = STK_HOLD;
        flags_nxt = flags_r;                                          // RQ17
        if (dv_done) begin
            acc_nxt = bin_to_bcd(dv_quot);                            // RQ1
            top_nxt = bin_to_bcd({16'h0000, dv_rem});
            stk_act = STK_TOP;                                        // RQ2
            flags_nxt.zero_result_flag     = (dv_quot == 32'h0000_0000);
            flags_nxt.negative_result_flag = 1'b0;
        end else if (ld_go) begin
            acc_nxt = ld_val;
            stk_act = STK_PUSH;                                       // RQ18
        end else if (op_go) begin
            unique case (op)
                arith_pkg::OP_ADD: begin
                    acc_nxt = sum33[31:0];
                    stk_act = STK_POP;                                // RQ8
                    flags_nxt.low_half_carry_flag   = sum17[16];      // RQ9
                    flags_nxt.full_width_carry_flag = sum33[32];      // RQ10
                    flags_nxt.signed_overflow_flag  = (acc_r[31] == stk_r[0][31])
                                                      && (sum33[31] != acc_r[31]); // RQ11
                end
                arith_pkg::OP_SUB: begin
                    acc_nxt = dif33[31:0];
                    stk_act = STK_POP;                                // RQ8
                    flags_nxt.low_half_borrow_flag   = acc_r[15:0] < stk_r[0][15:0]; // RQ13
                    flags_nxt.full_width_borrow_flag = dif33[32];     // RQ14
                    flags_nxt.signed_overflow_flag   = (acc_r[31] != stk_r[0][31])
                                                       && (dif33[31] != acc_r[31]); // RQ11
                end
                arith_pkg::OP_MUL: begin
                    acc_nxt = prod;                                   // RQ16
                    stk_act = STK_POP;                                // RQ8
                end
                arith_pkg::OP_DIV: begin
                    flags_nxt.invalid_digit_flag = !(bcd_ok(acc_r) && bcd_ok(stk_r[0])); // RQ4 RQ20
                    flags_nxt.range_err_flag     = (stk_r[0][31:16] != 16'h0000)
                                                   || (stk_r[0][15:0] == 16'h0000); // RQ3
                end
                default: begin
                end
            endcase
            if (op == arith_pkg::OP_ADD || op == arith_pkg::OP_SUB || op == arith_pkg::OP_MUL) begin
                flags_nxt.zero_result_flag     = (acc_nxt == 32'h0000_0000); // RQ5
                flags_nxt.negative_result_flag = acc_nxt[31];         // RQ6
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r   <= `ACC_RST;
            flags_r <= `FLAGS_RST;
        end else begin
            acc_r   <= acc_nxt;
            flags_r <= flags_nxt;
        end
    end

    // pop keeps the deepest level as is; its value is not defined to users
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `STK_DEPTH; i++) begin
                stk_r[i] <= `STK_RST;
            end
        end else begin
            unique case (stk_act)
                STK_PUSH: begin
                    stk_r[0] <= acc_r;                                // RQ18
                    for (int i = 1; i < `STK_DEPTH; i++) begin
                        stk_r[i] <= stk_r[i-1];                       // RQ19
                    end
                end
                STK_POP: begin
                    for (int i = 0; i < `STK_DEPTH-1; i++) begin
                        stk_r[i] <= stk_r[i+1];                       // RQ8
                    end
                end
                STK_TOP:  stk_r[0] <= top_nxt;                        // RQ2
                STK_HOLD: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= arith_pkg::ST_IDLE;
        end else if (div_start) begin
            state_r <= arith_pkg::ST_DIV;
        end else if (dv_done) begin
            state_r <= arith_pkg::ST_IDLE;
        end
    end

    // checking
    logic [31:0] chk_a_r;
    logic [31:0] chk_b_r;
    logic        add_go;
    logic        sub_go;
    logic        mul_go;
    assign add_go = op_go && (op == arith_pkg::OP_ADD);
    assign sub_go = op_go && (op == arith_pkg::OP_SUB);
    assign mul_go = op_go && (op == arith_pkg::OP_MUL);

    always_ff @(posedge clk_i) begin
        if (div_start) begin
            chk_a_r <= bcd_to_bin(acc_r);
            chk_b_r <= bcd_to_bin(stk_r[0]);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence div_issue_s;
        op_go && op == arith_pkg::OP_DIV && div_ok;
    endsequence
    sequence div_finish_s;
        dv_done && !idle;
    endsequence

    div_finish_a: assert property (div_issue_s |-> ##[30:40] div_finish_s) // RQ1
        else $error("divide never completed");
    div_math_a: assert property (div_finish_s |-> (dv_quot * chk_b_r + 32'(dv_rem) == chk_a_r) // RQ1
        && (32'(dv_rem) < chk_b_r))
        else $error("quotient and remainder wrong");
    div_remtop_a: assert property (div_finish_s |=> stk_r[0] == bin_to_bcd(32'($past(dv_rem))) // RQ2
        && $stable(stk_r[1]) && idle)
        else $error("remainder not in top level");
    div_range_a: assert property (op_go && op == arith_pkg::OP_DIV && stk_r[0][15:0] == 16'h0000 // RQ3
        |=> flags_r.range_err_flag && idle)
        else $error("range error not flagged");
    bad_digit_a: assert property (op_go && op == arith_pkg::OP_DIV && !bcd_ok(acc_r) // RQ4
        |=> flags_r.invalid_digit_flag && $stable(acc_r))
        else $error("invalid digit not flagged");
    zero_flag_a: assert property ((add_go || sub_go || mul_go || dv_done) // RQ5
        |=> flags_r.zero_result_flag == (acc_r == 32'h0000_0000))
        else $error("zero flag wrong");
    add_sum_a: assert property (add_go |=> acc_r == $past(acc_r) + $past(stk_r[0])) // RQ7
        else $error("add result wrong");
    pop_shift_a: assert property ((add_go || sub_go || mul_go) // RQ8
        |=> stk_r[0] == $past(stk_r[1]) && stk_r[6] == $past(stk_r[7]))
        else $error("stack did not move up");
    add_carry_a: assert property (add_go |=> flags_r.full_width_carry_flag == (acc_r < $past(acc_r)) // RQ10
        && flags_r.low_half_carry_flag == (acc_r[15:0] < $past(acc_r[15:0])))
        else $error("carry flags wrong");
    sub_borrow_a: assert property (sub_go |=> flags_r.full_width_borrow_flag // RQ14
        == ($past(acc_r) < $past(stk_r[0])) && acc_r + $past(stk_r[0]) == $past(acc_r))
        else $error("subtract or borrow wrong");
    mul_full_a: assert property (mul_go |=> acc_r == $past(acc_r[15:0]) * $past(stk_r[0][15:0]) // RQ16
        && flags_r.negative_result_flag == acc_r[31])
        else $error("product wrong");
    flags_hold_a: assert property ((ld_go || !(op_go || dv_done)) |=> $stable(flags_r)) // RQ17
        else $error("flags changed without an op");
    load_push_a: assert property (ld_go |=> stk_r[0] == $past(acc_r) && stk_r[7] == $past(stk_r[6])) // RQ18
        else $error("load did not push");
    busy_track_a: assert property (!idle == (dv_busy || dv_done)) // RQ1
        else $error("busy state and divider disagree");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    neg_flag_a: assert property ((add_go || sub_go) |=> flags_r.negative_result_flag == acc_r[31]) // RQ6
        else $error("sign flag wrong");
    sub_lowb_a: assert property (sub_go |=> flags_r.low_half_borrow_flag // RQ13
        == (acc_r[15:0] > $past(acc_r[15:0])))
        else $error("low-half borrow wrong");
    add_ovf_a: assert property (add_go |=> flags_r.signed_overflow_flag // RQ11
        == ($past(acc_r[31]) == $past(stk_r[0][31]) && acc_r[31] != $past(acc_r[31])))
        else $error("signed overflow on add wrong");
    sub_ovf_a: assert property (sub_go |=> flags_r.signed_overflow_flag // RQ11
        == ($past(acc_r[31]) != $past(stk_r[0][31]) && acc_r[31] != $past(acc_r[31])))
        else $error("signed overflow on subtract wrong");
endmodule

// ===== wb_sequencer.sv
`timescale 1ns/1ps

module wb_sequencer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rd_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [31:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    output logic             done_o,
    output logic [31:0]      rdata_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_o   <= 1'b0;
            stb_o   <= 1'b0;
            we_o    <= 1'b0;
            adr_o   <= 32'h0000_0000;
            sel_o   <= 4'h0;
            dat_o   <= 32'h0000_0000;
            done_o  <= 1'b0;
            rdata_o <= 32'h0000_0000;
        end else begin
            done_o <= 1'b0;
            if (cyc_o && ack_i) begin
                cyc_o   <= 1'b0;
                stb_o   <= 1'b0;
                // released lines turn over so stale values never look valid
                adr_o   <= ~adr_o;
                dat_o   <= ~dat_o;
                sel_o   <= 4'h0;
                // read data taken at the ack edge of every cycle, writes and reads alike
                rdata_o <= rd_i;
                done_o  <= 1'b1;
            end else if (!cyc_o && !done_o && go_i) begin
                cyc_o <= 1'b1;
                stb_o <= 1'b1;
                we_o  <= we_i;
                adr_o <= adr_i;
                sel_o <= sel_i;
                dat_o <= dat_i;
            end
        end
    end
endmodule

// ===== tb_stack_arith_unit.sv
`timescale 1ns/1ps
`include "arith_params.svh"

module tb_stack_arith_unit;
    typedef struct packed {
        arith_pkg::op_t op;
        logic [31:0]    a;
        logic [31:0]    t;
        logic [31:0]    acc;
        logic [31:0]    top;
        logic           pop;
        logic [8:0]     mask;
        logic [8:0]     fl;
    } row_t;

    localparam int N_ROWS = 19;

    logic        clk;
    logic        rst;
    logic        go;
    logic        we;
    logic [31:0] adr;
    logic [31:0] wdat;
    logic [3:0]  bsel;
    logic        cyc;
    logic        stb;
    logic        wb_we;
    logic [31:0] wb_adr;
    logic [3:0]  sel;
    logic [31:0] wb_dat;
    logic        ack;
    logic [31:0] rd;
    logic        done;
    logic [31:0] rdata;
    int          n_errors;
    int          checks_done;

    row_t rows [N_ROWS] = '{
        '{arith_pkg::OP_ADD, 32'h0000_ffff, 32'h1, 32'h0001_0000, 32'h0, 1'b1, 9'h079, 9'h008},
        '{arith_pkg::OP_ADD, 32'hffff_ffff, 32'h1, 32'h0, 32'h0, 1'b1, 9'h079, 9'h019},
        '{arith_pkg::OP_ADD, 32'h7fff_ffff, 32'h1, 32'h8000_0000, 32'h0, 1'b1, 9'h079, 9'h068},
        '{arith_pkg::OP_ADD, 32'h8000_0000, 32'h8000_0000, 32'h0, 32'h0, 1'b1, 9'h079, 9'h051},
        '{arith_pkg::OP_SUB, 32'h0, 32'h1, 32'hffff_ffff, 32'h0, 1'b1, 9'h067, 9'h026},
        '{arith_pkg::OP_SUB, 32'h8000_0000, 32'h1, 32'h7fff_ffff, 32'h0, 1'b1, 9'h067, 9'h042},
        '{arith_pkg::OP_SUB, 32'h7fff_ffff, 32'hffff_ffff, 32'h8000_0000, 32'h0, 1'b1, 9'h067, 9'h064},
        '{arith_pkg::OP_SUB, 32'h1234_5678, 32'h1234_5678, 32'h0, 32'h0, 1'b1, 9'h067, 9'h001},
        '{arith_pkg::OP_MUL, 32'hffff_0003, 32'habcd_ffff, 32'h0002_fffd, 32'h0, 1'b1, 9'h021, 9'h000},
        '{arith_pkg::OP_MUL, 32'h0000_ffff, 32'h0000_ffff, 32'hfffe_0001, 32'h0, 1'b1, 9'h021, 9'h020},
        '{arith_pkg::OP_MUL, 32'h0, 32'h1234, 32'h0, 32'h0, 1'b1, 9'h021, 9'h001},
        '{arith_pkg::OP_DIV, 32'h100, 32'h7, 32'h14, 32'h2, 1'b0, 9'h1a1, 9'h000},
        '{arith_pkg::OP_DIV, 32'h9999_9999, 32'h1, 32'h9999_9999, 32'h0, 1'b0, 9'h1a1, 9'h000},
        '{arith_pkg::OP_DIV, 32'h0, 32'h5, 32'h0, 32'h0, 1'b0, 9'h1a1, 9'h001},
        '{arith_pkg::OP_DIV, 32'h1234_5678, 32'h987, 32'h1_2508, 32'h282, 1'b0, 9'h1a1, 9'h000},
        '{arith_pkg::OP_DIV, 32'ha0, 32'h5, 32'ha0, 32'h5, 1'b0, 9'h180, 9'h080},
        '{arith_pkg::OP_DIV, 32'h10, 32'hf, 32'h10, 32'hf, 1'b0, 9'h180, 9'h080},
        '{arith_pkg::OP_DIV, 32'h10, 32'h0, 32'h10, 32'h0, 1'b0, 9'h180, 9'h100},
        '{arith_pkg::OP_DIV, 32'h10, 32'h1_0000, 32'h10, 32'h1_0000, 1'b0, 9'h180, 9'h100}
    };

    stack_arith_unit u_dut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(wb_we), .adr_i(wb_adr),
        .sel_i(sel), .dat_i(wb_dat), .ack_o(ack), .dat_o(rd)
    );

    wb_sequencer u_seq (
        .clk_i(clk), .rst_i(rst), .go_i(go), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(bsel),
        .ack_i(ack), .rd_i(rd), .cyc_o(cyc), .stb_o(stb), .we_o(wb_we), .adr_o(wb_adr),
        .sel_o(sel), .dat_o(wb_dat), .done_o(done), .rdata_o(rdata)
    );

    always #5 clk = ~clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic fail(input string what);
        n_errors++;
        $display("MISMATCH %0t %s", $time, what);
        close_out();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one whole bus cycle, handed to the sequencer model
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        go   <= 1'b1;
        we   <= w;
        adr  <= {24'h0, a};
        wdat <= d;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 50);
        if (done !== 1'b1) fail("bus cycle never acked");
        q = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic wait_idle();
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h1_0000;
        while (q[`BUSY_BIT] !== 1'b0 && n < 100) begin
            rdr(`OFS_FLAGS, q);
            n++;
        end
        if (q[`BUSY_BIT] !== 1'b0) fail("divide stays busy");
    endtask

    task automatic run_op(input arith_pkg::op_t o);
        wr(`OFS_CMD, {29'h0, o});
        wait_idle();
    endtask

    task automatic zero_state(input string name);
        logic [31:0] q;
        rdr(`OFS_ACC, q);
        chk(q, `ACC_RST, "acc reset");
        rdr(`OFS_TOP, q);
        chk(q, `STK_RST, "top reset");
        rdr(`OFS_FLAGS, q);
        chk(q, 32'h0, "flags reset");
        $display("test %s done", name);
    endtask

    initial begin
        logic [31:0] q;
        logic [31:0] prev;
        row_t        r;
        clk = 1'b0;
        rst = 1'b1;
        go = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        wdat = 32'h0;
        bsel = 4'hf;
        n_errors = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // read-only, unmapped and no-op writes must leave the state alone
        wr(`OFS_ACC, 32'h1234_5678);
        wr(8'h20, 32'hffff_ffff);
        wr(`OFS_CMD, 32'h0);
        wr(`OFS_CMD, 32'h7);
        rdr(8'h20, q);
        chk(q, 32'h0, "unmapped read");
        zero_state("reset");
        prev = 32'h0;
        for (int i = 0; i < N_ROWS; i++) begin
            r = rows[i];
            wr(`OFS_LOAD, r.t);
            wr(`OFS_LOAD, r.a);
            run_op(r.op);
            rdr(`OFS_ACC, q);
            chk(q, r.acc, "acc result");
            rdr(`OFS_TOP, q);
            chk(q, r.pop ? prev : r.top, "top after op");
            rdr(`OFS_FLAGS, q);
            chk({23'h0, q[8:0] & r.mask}, {23'h0, r.fl}, "flags");
            prev = r.acc;
        end
        $display("test table done");
        // carry and range survive a load and a multiply
        wr(`OFS_LOAD, 32'h1);
        wr(`OFS_LOAD, 32'h0000_ffff);
        run_op(arith_pkg::OP_ADD);
        wr(`OFS_LOAD, 32'h3);
        wr(`OFS_LOAD, 32'h2);
        run_op(arith_pkg::OP_MUL);
        rdr(`OFS_FLAGS, q);
        chk(q, 32'h108, "flags held");
        $display("test flag hold done");
        // loads and ops issued mid-divide are refused
        wr(`OFS_LOAD, 32'h1);
        wr(`OFS_LOAD, 32'h9999_9999);
        wr(`OFS_CMD, {29'h0, arith_pkg::OP_DIV});
        rdr(`OFS_FLAGS, q);
        chk({31'h0, q[`BUSY_BIT]}, 32'h1, "busy during divide");
        wr(`OFS_LOAD, 32'h5);
        wr(`OFS_CMD, {29'h0, arith_pkg::OP_ADD});
        wait_idle();
        rdr(`OFS_ACC, q);
        chk(q, 32'h9999_9999, "acc after busy writes");
        rdr(`OFS_TOP, q);
        chk(q, 32'h0, "remainder after busy writes");
        $display("test busy done");
        // ten pushes: only the last eight survive
        for (int k = 1; k <= 10; k++) wr(`OFS_LOAD, k);
        rdr(`OFS_TOP, q);
        chk(q, 32'h9, "top after pushes");
        repeat (7) run_op(arith_pkg::OP_ADD);
        rdr(`OFS_ACC, q);
        chk(q, 32'h34, "sum of stack");
        rdr(`OFS_TOP, q);
        chk(q, 32'h2, "deepest level");
        $display("test depth done");
        // unselected load bytes read zero, a command needs byte 0 selected
        bsel <= 4'h3;
        wr(`OFS_LOAD, 32'haabb_ccdd);
        bsel <= 4'he;
        wr(`OFS_CMD, {29'h0, arith_pkg::OP_ADD});
        bsel <= 4'hf;
        rdr(`OFS_ACC, q);
        chk(q, 32'h0000_ccdd, "partial load, no add");
        rdr(`OFS_TOP, q);
        chk(q, 32'h34, "pushed acc kept");
        $display("test byte select done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        zero_state("second reset");
        close_out();
    end
endmodule
